// ### common/cmj_pkg.sv
// constants, opcodes and carriers for the move, jump and multiply slice
package cmj_pkg;

    localparam int unsigned CLK_PERIOD_NS   = 8;
    // execution lengths in clock cycles
    localparam int unsigned JMP_CYCLES      = 3;
    localparam int unsigned STORE_BLK_CYC   = 4;
    localparam int unsigned STORE_NBLK_CYC  = 1;
    localparam logic [2:0]  JMP_WAIT        = 3'(JMP_CYCLES - 1);
    localparam logic [2:0]  STORE_WAIT      = 3'(STORE_BLK_CYC - 1);
    localparam logic [7:0]  ADDR_STEP       = 8'h02;

    // status register layout
    localparam int unsigned ST_CARRY_BIT    = 0;
    localparam int unsigned ST_ZERO_BIT     = 2;
    localparam int unsigned ST_BANK_LSB     = 5;
    localparam int unsigned ST_BANK_MSB     = 7;
    localparam logic [7:0]  STATUS_RST      = 8'h00;
    localparam logic [7:0]  BYTE_RST        = 8'h00;
    localparam logic [15:0] PC_RST          = 16'h0000;

    // program RAM window in the 24-bit space
    localparam logic [23:0] PRAM_FIRST      = 24'h000000;
    localparam logic [23:0] PRAM_LAST       = 24'h00ffff;

    // byte-register selects on the pointer write port
    localparam logic [2:0]  SEL_ADDR_X      = 3'h0;
    localparam logic [2:0]  SEL_ADDR_H      = 3'h1;
    localparam logic [2:0]  SEL_ADDR_L      = 3'h2;
    localparam logic [2:0]  SEL_DATA_H      = 3'h3;
    localparam logic [2:0]  SEL_DATA_L      = 3'h4;

    // opcode value and mask pairs
    localparam logic [15:0] OPM_FULL        = 16'hffff;
    localparam logic [15:0] OPM_PAGE        = 16'hfff8;
    localparam logic [15:0] OPM_JMP         = 16'he000;
    localparam logic [15:0] OPM_LIT         = 16'hff00;
    localparam logic [15:0] OPM_FILE        = 16'hfe00;
    localparam logic [15:0] OPV_IWRITEI     = 16'h001c;
    localparam logic [15:0] OPV_PAGE        = 16'h0010;
    localparam logic [15:0] OPV_JMP         = 16'he000;
    localparam logic [15:0] OPV_LOADH       = 16'h7000;
    localparam logic [15:0] OPV_LOADL       = 16'h7100;
    localparam logic [15:0] OPV_MULUL       = 16'h7200;
    localparam logic [15:0] OPV_MULSL       = 16'h7300;
    localparam logic [15:0] OPV_MOVWL       = 16'h7c00;
    localparam logic [15:0] OPV_MOVFW       = 16'h0200;
    localparam logic [15:0] OPV_MULSF       = 16'h0400;
    localparam logic [15:0] OPV_MOVWF       = 16'h2000;
    localparam logic [15:0] OPV_MULUF       = 16'h5000;

    typedef enum logic [3:0] {
        OP_NONE, OP_IWRITEI, OP_PAGE, OP_JMP, OP_LOADH, OP_LOADL, OP_MOVFW,
        OP_MOVWF, OP_MOVWL, OP_MULSF, OP_MULSL, OP_MULUF, OP_MULUL
    } cmj_op_t;

    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_JUMP  = 3'b010,
        ST_STORE = 3'b100
    } cmj_state_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] word;
    } cmj_instr_t;

    typedef struct packed {
        logic       we;
        logic [2:0] sel;
        logic [7:0] data;
    } cmj_regwr_t;

    typedef struct packed {
        logic        we;
        logic [23:0] addr;
        logic [15:0] data;
    } cmj_pram_wr_t;

    typedef struct packed {
        logic       we;
        logic [8:0] addr;
        logic [7:0] data;
    } cmj_dm_wr_t;

endpackage

// ### design/cmj_exec.sv
// decode and execute of moves, paged jump, pointer loads, multiplies and RAM store
`timescale 1ns/1ps
`default_nettype none

module cmj_exec (
    input  wire logic                  I_CORE_CLK,
    input  wire logic                  I_RST,
    input  wire cmj_pkg::cmj_instr_t   I_INSTR,
    input  wire logic                  I_SKIP_TAKEN,
    input  wire logic [7:0]            I_FR_DATA,
    input  wire logic                  I_CARRY_WE,
    input  wire logic                  I_CARRY_IN,
    input  wire cmj_pkg::cmj_regwr_t   I_PTR_WR,
    output logic                       O_BUSY,
    output logic                       O_SQUASH,
    output logic                       O_PC_LOAD,
    output logic [15:0]                O_PC,
    output logic [7:0]                 O_W,
    output logic [7:0]                 O_STATUS,
    output logic [7:0]                 O_PRODUCT_HIGH,
    output logic [7:0]                 O_DP_HIGH,
    output logic [7:0]                 O_DP_LOW,
    output logic [23:0]                O_ADDR,
    output logic [15:0]                O_DATA_WORD,
    output cmj_pkg::cmj_pram_wr_t      O_PRAM_WR,
    output cmj_pkg::cmj_dm_wr_t        O_DM_WR
);
    import cmj_pkg::*;

    // classify one instruction word
    function automatic cmj_op_t decode(input logic [15:0] w);
        cmj_op_t op;
        op = OP_NONE;
        if ((w & OPM_FULL) == OPV_IWRITEI) begin
            op = OP_IWRITEI;
        end else if ((w & OPM_PAGE) == OPV_PAGE) begin
            op = OP_PAGE;
        end else if ((w & OPM_JMP) == OPV_JMP) begin
            op = OP_JMP;
        end else if ((w & OPM_LIT) == OPV_LOADH) begin
            op = OP_LOADH;
        end else if ((w & OPM_LIT) == OPV_LOADL) begin
            op = OP_LOADL;
        end else if ((w & OPM_LIT) == OPV_MULUL) begin
            op = OP_MULUL;
        end else if ((w & OPM_LIT) == OPV_MULSL) begin
            op = OP_MULSL;
        end else if ((w & OPM_LIT) == OPV_MOVWL) begin
            op = OP_MOVWL;
        end else if ((w & OPM_FILE) == OPV_MOVFW) begin
            op = OP_MOVFW;
        end else if ((w & OPM_FILE) == OPV_MULSF) begin
            op = OP_MULSF;
        end else if ((w & OPM_FILE) == OPV_MOVWF) begin
            op = OP_MOVWF;
        end else if ((w & OPM_FILE) == OPV_MULUF) begin
            op = OP_MULUF;
        end
        return op;
    endfunction

    // 8x8 multiply, signed or unsigned, full 16-bit product
    function automatic logic [15:0] mul16(input logic [7:0] a, input logic [7:0] b,
                                          input logic sgn);
        logic signed [15:0] sa;
        logic signed [15:0] sb;
        logic signed [15:0] sp;
        logic [15:0]        up;
        sa = sgn ? 16'(signed'(a)) : 16'(a);
        sb = sgn ? 16'(signed'(b)) : 16'(b);
        sp = sa * sb;
        up = 16'(a) * 16'(b);
        return sgn ? 16'(sp) : up;
    endfunction

    cmj_state_t   state_ff;
    cmj_state_t   nxt_state;
    logic [2:0]   wait_ff;
    logic [2:0]   nxt_wait;
    logic         busy_ff;
    logic         skip_pend_ff;
    logic [7:0]   w_ff;
    logic [7:0]   status_ff;
    logic [7:0]   prod_hi_ff;
    logic [7:0]   dp_hi_ff;
    logic [7:0]   dp_lo_ff;
    logic [7:0]   addr_x_ff;
    logic [7:0]   addr_h_ff;
    logic [7:0]   addr_l_ff;
    logic [7:0]   data_h_ff;
    logic [7:0]   data_l_ff;
    logic [15:0]  pc_ff;
    logic         pc_load_ff;
    logic         squash_ff;
    cmj_pram_wr_t pram_wr_ff;
    cmj_dm_wr_t   dm_wr_ff;

    logic         accept;
    logic         squash;
    logic         exec;
    cmj_op_t      op;
    logic [7:0]   imm8;
    logic [23:0]  st_addr;
    logic         st_in_pram;
    logic [15:0]  product;
    logic         is_mul;

    assign accept     = I_INSTR.valid && (state_ff == ST_RUN);
    assign op         = decode(I_INSTR.word);
    assign squash     = accept && skip_pend_ff;
    assign exec       = accept && !skip_pend_ff;
    assign imm8       = I_INSTR.word[7:0];
    assign st_addr    = {addr_x_ff, addr_h_ff, addr_l_ff};
    assign st_in_pram = (st_addr >= PRAM_FIRST) && (st_addr <= PRAM_LAST);
    assign is_mul     = (op == OP_MULSF) || (op == OP_MULSL) ||
                        (op == OP_MULUF) || (op == OP_MULUL);
    always_comb begin
        case (op)
            OP_MULSF: product = mul16(w_ff, I_FR_DATA, 1'b1);
            OP_MULSL: product = mul16(w_ff, imm8, 1'b1);
            OP_MULUF: product = mul16(w_ff, I_FR_DATA, 1'b0);
            OP_MULUL: product = mul16(w_ff, imm8, 1'b0);
            default:  product = 16'h0000;
        endcase
    end

    // sequencing of multi-cycle instructions
    always_comb begin
        nxt_state = state_ff;
        nxt_wait  = wait_ff;
        case (state_ff)
            ST_RUN: begin
                if (exec && op == OP_JMP) begin
                    nxt_state = ST_JUMP;
                    nxt_wait  = JMP_WAIT;
                end else if (exec && op == OP_IWRITEI && st_in_pram) begin
                    nxt_state = ST_STORE;
                    nxt_wait  = STORE_WAIT;
                end
            end
            ST_JUMP, ST_STORE: begin
                nxt_wait = wait_ff - 3'h1;
                if (wait_ff == 3'h1) begin
                    nxt_state = ST_RUN;
                end
            end
            default: begin
                nxt_state = ST_RUN;
                nxt_wait  = 3'h0;
            end
        endcase
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            state_ff <= ST_RUN;
            wait_ff  <= 3'h0;
            busy_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            wait_ff  <= nxt_wait;
            busy_ff  <= (nxt_state != ST_RUN);
        end
    end

    // skip chain: bank select and pointer loads extend a taken skip
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            skip_pend_ff <= 1'b0;
            squash_ff    <= 1'b0;
        end else begin
            squash_ff <= squash;
            if (squash) begin
                skip_pend_ff <= (op == OP_PAGE) || (op == OP_LOADH) ||
                                (op == OP_LOADL);
            end else if (exec) begin
                skip_pend_ff <= I_SKIP_TAKEN;
            end
        end
    end

    // accumulator and product high byte
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            w_ff       <= BYTE_RST;
            prod_hi_ff <= BYTE_RST;
        end else if (exec) begin
            if (op == OP_MOVWF) begin
                w_ff <= I_FR_DATA;
            end else if (op == OP_MOVWL) begin
                w_ff <= imm8;
            end else if (is_mul) begin
                w_ff       <= product[7:0];
                prod_hi_ff <= product[15:8];
            end
        end
    end

    // status: carry at bit 0, zero flag, bank bits 7:5
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            status_ff <= STATUS_RST;
        end else begin
            if (I_CARRY_WE) begin
                status_ff[ST_CARRY_BIT] <= I_CARRY_IN;
            end
            if (exec && op == OP_MOVWF) begin
                status_ff[ST_ZERO_BIT] <= (I_FR_DATA == 8'h00);
            end
            if (exec && op == OP_PAGE) begin
                status_ff[ST_BANK_MSB:ST_BANK_LSB] <= I_INSTR.word[2:0];
            end
        end
    end

    // data pointer bytes
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            dp_hi_ff <= BYTE_RST;
            dp_lo_ff <= BYTE_RST;
        end else if (exec) begin
            if (op == OP_LOADH) begin
                dp_hi_ff <= imm8;
            end
            if (op == OP_LOADL) begin
                dp_lo_ff <= imm8;
            end
        end
    end

    // store address and data bytes; store increment wins over port write
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            addr_x_ff <= BYTE_RST;
            addr_h_ff <= BYTE_RST;
            addr_l_ff <= BYTE_RST;
            data_h_ff <= BYTE_RST;
            data_l_ff <= BYTE_RST;
        end else begin
            if (I_PTR_WR.we) begin
                case (I_PTR_WR.sel)
                    SEL_ADDR_X: addr_x_ff <= I_PTR_WR.data;
                    SEL_ADDR_H: addr_h_ff <= I_PTR_WR.data;
                    SEL_ADDR_L: addr_l_ff <= I_PTR_WR.data;
                    SEL_DATA_H: data_h_ff <= I_PTR_WR.data;
                    SEL_DATA_L: data_l_ff <= I_PTR_WR.data;
                    default: begin
                    end
                endcase
            end
            if (exec && op == OP_IWRITEI) begin
                addr_l_ff <= addr_l_ff + ADDR_STEP;
            end
        end
    end

    // program RAM write pulse
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            pram_wr_ff <= '0;
        end else begin
            pram_wr_ff.we <= exec && (op == OP_IWRITEI) && st_in_pram;
            if (exec && op == OP_IWRITEI) begin
                pram_wr_ff.addr <= st_addr;
                pram_wr_ff.data <= {data_h_ff, data_l_ff};
            end
        end
    end

    // data memory write pulse
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            dm_wr_ff <= '0;
        end else begin
            dm_wr_ff.we <= exec && (op == OP_MOVFW);
            if (exec && op == OP_MOVFW) begin
                dm_wr_ff.addr <= I_INSTR.word[8:0];
                dm_wr_ff.data <= w_ff;
            end
        end
    end

    // program counter load
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            pc_ff      <= PC_RST;
            pc_load_ff <= 1'b0;
        end else begin
            pc_load_ff <= exec && (op == OP_JMP);
            if (exec && op == OP_JMP) begin
                pc_ff <= {status_ff[ST_BANK_MSB:ST_BANK_LSB], I_INSTR.word[12:0]};
            end
        end
    end

    assign O_BUSY         = busy_ff;
    assign O_SQUASH       = squash_ff;
    assign O_PC_LOAD      = pc_load_ff;
    assign O_PC           = pc_ff;
    assign O_W            = w_ff;
    assign O_STATUS       = status_ff;
    assign O_PRODUCT_HIGH = prod_hi_ff;
    assign O_DP_HIGH      = dp_hi_ff;
    assign O_DP_LOW       = dp_lo_ff;
    assign O_ADDR         = st_addr;
    assign O_DATA_WORD    = {data_h_ff, data_l_ff};
    assign O_PRAM_WR      = pram_wr_ff;
    assign O_DM_WR        = dm_wr_ff;

endmodule

`default_nettype wire

// ### tb/cmj_exec_properties.sv
// assertion checker for the move, jump and multiply slice
`timescale 1ns/1ps
`default_nettype none
module cmj_exec_props (
    input wire logic                   I_CORE_CLK,
    input wire logic                   I_RST,
    input wire cmj_pkg::cmj_instr_t    I_INSTR,
    input wire logic                   I_CARRY_WE,
    input wire logic                   I_CARRY_IN,
    input wire logic                   O_BUSY,
    input wire logic                   O_SQUASH,
    input wire logic                   O_PC_LOAD,
    input wire logic [15:0]            O_PC,
    input wire logic [7:0]             O_W,
    input wire logic [7:0]             O_STATUS,
    input wire logic [23:0]            O_ADDR,
    input wire logic [15:0]            O_DATA_WORD,
    input wire cmj_pkg::cmj_pram_wr_t  O_PRAM_WR,
    input wire cmj_pkg::cmj_dm_wr_t    O_DM_WR
);
    import cmj_pkg::*;
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);
    AST_JMP_LEN: assert property (O_PC_LOAD |-> O_BUSY ##1 O_BUSY ##1 !O_BUSY)
        else $error("jump occupancy wrong");
    AST_JMP_TARGET: assert property (O_PC_LOAD |-> O_PC ==
        {$past(O_STATUS[7:5]), $past(I_INSTR.word[12:0])}) else $error("jump target wrong");
    AST_ST_LEN: assert property (O_PRAM_WR.we |-> O_BUSY [*3] ##1 !O_BUSY)
        else $error("store occupancy wrong");
    AST_ST_RANGE: assert property (O_PRAM_WR.we |-> O_PRAM_WR.addr <= PRAM_LAST)
        else $error("store outside program RAM");
    AST_ST_WORD: assert property (O_PRAM_WR.we |-> O_PRAM_WR.data == $past(O_DATA_WORD)
        && O_PRAM_WR.addr == $past(O_ADDR)) else $error("store word or address wrong");
    AST_ST_STEP: assert property (O_PRAM_WR.we |-> O_ADDR ==
        {$past(O_ADDR[23:8]), 8'($past(O_ADDR[7:0]) + ADDR_STEP)}) else $error("step wrong");
    AST_DM_WR: assert property (O_DM_WR.we |-> O_DM_WR.data == $past(O_W) && O_W == $past(O_W)
        && O_DM_WR.addr == $past(I_INSTR.word[8:0])) else $error("file store wrong");
    AST_BUSY_REFUSE: assert property (O_BUSY |=> !O_DM_WR.we && !O_PRAM_WR.we)
        else $error("offer taken while busy");
    AST_SQUASH_QUIET: assert property (O_SQUASH |-> !O_PRAM_WR.we && !O_DM_WR.we && !O_PC_LOAD)
        else $error("skipped word had an effect");
    AST_CARRY: assert property (I_CARRY_WE |=> O_STATUS[ST_CARRY_BIT] == $past(I_CARRY_IN))
        else $error("carry bit wrong");
endmodule
bind cmj_exec cmj_exec_props u_props (
    .I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_INSTR(I_INSTR),
    .I_CARRY_WE(I_CARRY_WE), .I_CARRY_IN(I_CARRY_IN), .O_BUSY(O_BUSY),
    .O_SQUASH(O_SQUASH), .O_PC_LOAD(O_PC_LOAD), .O_PC(O_PC), .O_W(O_W),
    .O_STATUS(O_STATUS), .O_ADDR(O_ADDR), .O_DATA_WORD(O_DATA_WORD),
    .O_PRAM_WR(O_PRAM_WR), .O_DM_WR(O_DM_WR));
`default_nettype wire

// ### tb/cmj_exec_tb.sv
// self-checking bench for the move, jump and multiply slice
`timescale 1ns/1ps
`default_nettype none
module cmj_exec_tb;
    import cmj_pkg::*;
    logic         clk, rst, sk, cwe, cin, busy, squash, pcl;
    cmj_instr_t   ins;
    cmj_regwr_t   pw;
    cmj_pram_wr_t pwr;
    cmj_dm_wr_t   dwr;
    logic [7:0]   fr, w, st, ph, data_pointer_high, data_pointer_low, mw, mst, mph, mdh, mdl;
    logic [7:0]   bm [512];
    logic [15:0]  pc, dw, md;
    logic [15:0]  mt [4];
    logic [23:0]  addr, ma;
    logic [31:0]  r;
    int           seed, bad_count, tests_run;
    cmj_exec u_dut (
        .I_CORE_CLK(clk), .I_RST(rst), .I_INSTR(ins), .I_SKIP_TAKEN(sk),
        .I_FR_DATA(fr), .I_CARRY_WE(cwe), .I_CARRY_IN(cin), .I_PTR_WR(pw),
        .O_BUSY(busy), .O_SQUASH(squash), .O_PC_LOAD(pcl), .O_PC(pc),
        .O_W(w), .O_STATUS(st), .O_PRODUCT_HIGH(ph), .O_DP_HIGH(data_pointer_high),
        .O_DP_LOW(data_pointer_low), .O_ADDR(addr), .O_DATA_WORD(dw), .O_PRAM_WR(pwr),
        .O_DM_WR(dwr));
    cmj_mem_model u_mem (.i_clk(clk), .i_instr(ins), .i_pram_wr(pwr), .i_dm_wr(dwr),
        .o_fr_data(fr));
    initial begin
        clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clk = ~clk;
    end
    task automatic chk(input logic [23:0] s, input logic [23:0] e);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk_all;
        chk(w, mw);
        chk(st, mst);
        chk(ph, mph);
        chk({data_pointer_high, data_pointer_low}, {mdh, mdl});
        chk(addr, ma);
        chk(dw, md);
    endtask
    task automatic issue(input logic [15:0] wd, input logic s);
        @(negedge clk);
        ins = '{1'b1, wd};
        sk = s;
        @(posedge clk);
    endtask
    task automatic idle;
        @(negedge clk);
        ins.valid = 1'b0;
        sk = 1'b0;
    endtask
    task automatic wait_free(output int nb);
        nb = 0;
        while (busy === 1'b1) begin
            nb++;
            if (nb > 8) begin
                bad_count++;
                tally_and_finish;
            end
            @(negedge clk);
        end
    endtask
    task automatic do_op(input logic [15:0] wd);
        int nb;
        logic jmp, str, ok;
        logic [7:0] fb;
        issue(wd, 1'b0);
        idle;
        jmp = (wd & OPM_JMP) == OPV_JMP;
        str = wd == OPV_IWRITEI;
        ok = str && ma <= PRAM_LAST;
        fb = bm[wd[8:0]];
        chk(pcl, jmp);
        if (jmp) chk(pc, {mst[7:5], wd[12:0]});
        chk(pwr.we, ok);
        if (ok) chk(pwr.addr, ma);
        if (ok) chk(pwr.data, md);
        chk(dwr.we, (wd & OPM_FILE) == OPV_MOVFW);
        if (str) ma[7:0] = ma[7:0] + ADDR_STEP;
        if ((wd & OPM_PAGE) == OPV_PAGE) mst[7:5] = wd[2:0];
        case (wd & OPM_LIT)
            OPV_MOVWL: mw = wd[7:0];
            OPV_LOADH: mdh = wd[7:0];
            OPV_LOADL: mdl = wd[7:0];
            OPV_MULSL: {mph, mw} = $signed(mw) * $signed(wd[7:0]);
            OPV_MULUL: {mph, mw} = mw * wd[7:0];
            default: ;
        endcase
        case (wd & OPM_FILE)
            OPV_MOVFW: bm[wd[8:0]] = mw;
            OPV_MOVWF: begin
                mw = fb;
                mst[ST_ZERO_BIT] = fb == 8'h00;
            end
            OPV_MULSF: {mph, mw} = $signed(mw) * $signed(fb);
            OPV_MULUF: {mph, mw} = mw * fb;
            default: ;
        endcase
        chk_all;
        wait_free(nb);
        chk(24'(nb), 24'(jmp ? JMP_CYCLES - 1 : ok ? STORE_BLK_CYC - 1 : 0));
    endtask
    task automatic ptr(input logic [2:0] s, input logic [7:0] d);
        @(negedge clk);
        pw = '{1'b1, s, d};
        @(negedge clk);
        pw.we = 1'b0;
        case (s)
            SEL_ADDR_X: ma[23:16] = d;
            SEL_ADDR_H: ma[15:8] = d;
            SEL_ADDR_L: ma[7:0] = d;
            SEL_DATA_H: md[15:8] = d;
            SEL_DATA_L: md[7:0] = d;
            default: ;
        endcase
        chk_all;
    endtask
    task automatic setp(input logic [23:0] a, input logic [15:0] d);
        ptr(SEL_ADDR_X, a[23:16]);
        ptr(SEL_ADDR_H, a[15:8]);
        ptr(SEL_ADDR_L, a[7:0]);
        ptr(SEL_DATA_H, d[15:8]);
        ptr(SEL_DATA_L, d[7:0]);
    endtask
    task automatic carry(input logic v);
        @(negedge clk);
        cwe = 1'b1;
        cin = v;
        @(negedge clk);
        cwe = 1'b0;
        mst[ST_CARRY_BIT] = v;
        chk_all;
    endtask
    task automatic skip3(input logic [15:0] a, input logic [15:0] b);
        issue(16'h0000, 1'b1);
        issue(a, 1'b0);
        issue(b, 1'b0);
        idle;
        chk(squash, 1'b1);
        chk(pcl, 1'b0);
        chk_all;
    endtask
    initial begin
        seed = 12;
        {bad_count, tests_run} = '0;
        {rst, sk, cwe, cin} = 4'b1000;
        ins = '0;
        pw = '0;
        {mw, mst, mph, mdh, mdl, ma, md} = '0;
        for (int i = 0; i < 512; i++) bm[i] = 8'h00;
        mt = '{OPV_MULSF, OPV_MULSL, OPV_MULUF, OPV_MULUL};
        repeat (4) @(negedge clk);
        rst = 1'b0;
        chk_all;
        chk({busy, squash, pcl, pwr.we, dwr.we}, 5'h00);
        do_op(OPV_MOVWL | 16'h003c);
        do_op(OPV_MOVFW | 16'h01a5);
        do_op(OPV_MOVWF | 16'h0033);
        do_op(OPV_MOVWF | 16'h01a5);
        do_op(OPV_MOVWL | 16'h00f9);
        do_op(OPV_MULSL | 16'h00fa);
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            do_op(OPV_MOVWL | r[7:0]);
            do_op(OPV_MOVFW | r[16:8]);
            do_op(OPV_MOVWL | r[31:24]);
            do_op(mt[i % 4] | (i[0] ? r[23:16] : r[16:8]));
            do_op(OPV_LOADH | r[15:8]);
            do_op(OPV_LOADL | r[23:16]);
        end
        for (int b = 0; b < 8; b++) begin
            r = $random(seed);
            do_op(OPV_PAGE | 16'(b));
            do_op(OPV_JMP | r[12:0]);
        end
        setp(24'h000380, r[15:0]);
        do_op(OPV_IWRITEI);
        do_op(OPV_IWRITEI);
        setp(24'h00fffe, r[31:16]);
        do_op(OPV_IWRITEI);
        setp(24'h010000, r[15:0]);
        do_op(OPV_IWRITEI);
        ptr(3'h7, r[7:0]);
        chk(24'(u_mem.pram_cnt), 24'd3);
        carry(1'b1);
        carry(1'b0);
        carry(1'b1);
        skip3(OPV_PAGE | 16'h0005, OPV_JMP | 16'h0123);
        skip3(OPV_LOADL | 16'h0066, OPV_MOVWL | 16'h0011);
        skip3(OPV_LOADH | 16'h0077, OPV_MULUL | 16'h0003);
        do_op(OPV_MOVWL | 16'h0042);
        tally_and_finish;
    end
endmodule
`default_nettype wire

// ### tb/cmj_mem_model.sv
// data memory model and program RAM write counter on the far side of the slice
`timescale 1ns/1ps
`default_nettype none
module cmj_mem_model (
    input  wire logic                   i_clk,
    input  wire cmj_pkg::cmj_instr_t    i_instr,
    input  wire cmj_pkg::cmj_pram_wr_t  i_pram_wr,
    input  wire cmj_pkg::cmj_dm_wr_t    i_dm_wr,
    output logic [7:0]                  o_fr_data
);
    import cmj_pkg::*;
    logic [7:0] dmem [512];
    int         pram_cnt;
    initial begin
        for (int i = 0; i < 512; i++) dmem[i] = 8'h00;
        pram_cnt = 0;
    end
    // no offer: show inverted byte rather than a stale one
    assign o_fr_data = i_instr.valid ? dmem[i_instr.word[8:0]] : ~dmem[i_instr.word[8:0]];
    always @(posedge i_clk) begin
        if (i_dm_wr.we) dmem[i_dm_wr.addr] <= i_dm_wr.data;
        if (i_pram_wr.we) pram_cnt <= pram_cnt + 1;
    end
endmodule
`default_nettype wire
